// ===== verilog/irq_map.svh
// Register offsets, field positions, reset values of the interrupt mapping block
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
`define OFS_PIN_SEL 8'h0d
`define OFS_FILL_TX 8'h0e
`define OFS_THRESH 8'h0f
`define OFS_MODE 8'h10
`define RST_PIN_SEL 8'h00
`define RST_FILL_TX 8'h01
`define RST_THRESH 8'h00
`define RST_MODE 8'h00
`define B_OVERRUN 0
`define B_NOT_EMPTY 1
`define B_FULL 2
`define B_TX_SEL1 3
`define B_FILL_METHOD 7
`define B_FILL 6
`define B_TX_DONE 5
`define B_TX_START 4
`define B_SS_EN 3
`define B_SS_FLAG 2
`define B_PLL 1
`define B_LOCK_EN 0
`endif

// ===== verilog/irq_pkg.sv
// Types of the interrupt mapping block
package irq_pkg;
	typedef enum logic [1:0] {MODE_CONT, MODE_BUF, MODE_PKT0, MODE_PKT1} data_mode_t;
	typedef enum logic [1:0] {OP_STBY, OP_RX, OP_TX, OP_SLEEP} op_state_t;
	typedef struct packed {
		logic sync_det;
		logic adrs_match;
		logic addr_filt_en;
		logic write_byte;
		logic payload_ready;
		logic crc_ok;
		logic fifo_threshold;
		logic bit_clock;
		logic fifo_full;
		logic fifo_empty;
		logic overrun;
		logic shift_done;
		logic pll_lock;
	} events_t;
endpackage

// ===== verilog/irq_source_mapping.sv
// Interrupt source selection, FIFO flags, fill and start control
//
// Overview of operation
// - Continuous rx/standby: pin 0 gives sync, except code 01 gives signal strength.
// - Buffered rx/standby pin 0: none, byte written, not-empty, sync.
// - Packet pin 0: payload ready, byte written, not-empty, sync or address match.
// - Rx/standby pin 1: bit clock continuous; else none/crc, full, strength, threshold.
// - Transmit pin 1: bit clock continuous; else select bit picks full or done.
// - Read-only full bit high while FIFO holds maximum content.
// - Read-only not-empty bit goes low while FIFO is empty.
// - Overrun sets flag; writing one clears flag and FIFO.
// - Buffered fill method 0 fills on sync; 1 hands control to fill bit.
// - Auto fill bit high while filling; writing one re-arms if no overrun.
// - Manual method: software fill bit stops or starts FIFO loading.
// - Transmit-done flag rises after last bit leaves shift register.
// - Buffered start bit: 0 start on full, 1 on not-empty; pin 0 not-empty.
// - Packet start bit: 0 start at threshold, pin threshold; 1 not-empty.
// - Reserved bit 3 zero disables signal strength source; software sets it.
// - Strength above threshold sets flag; writing one clears it.
// - PLL lock flag reports lock; writing one clears it.
// - Lock enable 1 drives lock pin; 0 leaves it high impedance.
// - Eight-bit threshold register, reset zero, same scale as strength reading.
`timescale 1ns/1ps
`default_nettype none
`include "irq_map.svh"
module irq_source_mapping
	import irq_pkg::*;
#(
	parameter int RSSI_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Operating state and events
	input wire op_state_t op_state_i,
	input wire events_t ev_i,
	input wire logic [RSSI_W-1:0] rssi_i,
	// Interrupt pins and lock pin
	output logic irq0_o,
	output logic irq1_o,
	output logic lock_o,
	output logic lock_oe_o,
	// FIFO control
	output logic fifo_clear_o,
	output logic fifo_load_o,
	output logic tx_start_o
);

	// ****************************************
	// Parameter check
	// ****************************************
	generate
		if (RSSI_W != 8) begin : g_width_check
			$error("RSSI_W must be 8");
		end
	endgenerate

	// ****************************************
	// Register bus
	// ****************************************
	logic [7:0] sel13_q, sel13_d;
	logic [7:0] ctl14_q, ctl14_d;
	logic [7:0] thresh_q;
	logic [1:0] mode_q;
	logic overrun_q, fill_q, txdone_q, ssflag_q, pll_q, armed_q;
	logic [31:0] rdata_d;
	wire acc = cyc_i & stb_i & ~ack_o;
	wire wr = acc & we_i & sel_i[0];
	wire wr13 = wr & (adr_i == (`OFS_PIN_SEL << 2));
	wire wr14 = wr & (adr_i == (`OFS_FILL_TX << 2));
	wire wr15 = wr & (adr_i == (`OFS_THRESH << 2));
	wire wr16 = wr & (adr_i == (`OFS_MODE << 2));
	wire [7:0] wb = dat_i[7:0];
	wire data_mode_t dmode = data_mode_t'(mode_q);
	wire is_cont = (dmode == MODE_CONT);
	wire is_buf = (dmode == MODE_BUF);
	wire is_pkt = mode_q[1];
	wire in_tx = (op_state_i == OP_TX);

	// Status bits seen by software
	wire not_empty = ~ev_i.fifo_empty;
	wire full = ev_i.fifo_full;
	wire [7:0] rd13 = {sel13_q[7:3], full, not_empty, overrun_q};
	wire [7:0] rd14 = {ctl14_q[7], fill_q, txdone_q, ctl14_q[4:3], ssflag_q, pll_q, ctl14_q[0]};

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (adr_i)
			(`OFS_PIN_SEL << 2): rdata_d[7:0] = rd13;
			(`OFS_FILL_TX << 2): rdata_d[7:0] = rd14;
			(`OFS_THRESH << 2): rdata_d[7:0] = thresh_q;
			(`OFS_MODE << 2): rdata_d[1:0] = mode_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= acc;
			dat_o <= acc ? rdata_d : 32'h0000_0000;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	assign sel13_d = wr13 ? {wb[7:3], 3'h0} : sel13_q;
	assign ctl14_d = wr14 ? {wb[7], 2'h0, wb[4:3], 2'h0, wb[0]} : ctl14_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel13_q <= `RST_PIN_SEL;
			ctl14_q <= `RST_FILL_TX;
			thresh_q <= `RST_THRESH;
			mode_q <= 2'h0;
		end else begin
			sel13_q <= sel13_d;
			ctl14_q <= ctl14_d;
			if (wr15) thresh_q <= wb;
			if (wr16) mode_q <= wb[1:0];
		end
	end

	// ****************************************
	// Sticky flag strobes, set wins over clear
	// ****************************************
	wire ss_en = ctl14_q[`B_SS_EN];
	wire ss_above = ss_en & (rssi_i > thresh_q);
	wire ss_clr = wr14 & wb[`B_SS_FLAG];
	wire pll_clr = wr14 & wb[`B_PLL];
	wire ovr_clr = wr13 & wb[`B_OVERRUN];
	wire overrun_d = ev_i.overrun | (overrun_q & ~ovr_clr);
	wire txdone_d = ev_i.shift_done | (txdone_q & ~tx_start_o);
	wire ssflag_d = ss_above | (ssflag_q & ~ss_clr);
	wire pll_d = ev_i.pll_lock | (pll_q & ~pll_clr);

	// ****************************************
	// Overrun flag
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overrun_q <= 1'b0;
		end else begin
			overrun_q <= overrun_d;
		end
	end

	// ****************************************
	// Transmit done flag
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txdone_q <= 1'b0;
		end else begin
			txdone_q <= txdone_d;
		end
	end

	// ****************************************
	// Signal strength flag
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ssflag_q <= 1'b0;
		end else begin
			ssflag_q <= ssflag_d;
		end
	end

	// ****************************************
	// PLL lock flag
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_q <= 1'b0;
		end else begin
			pll_q <= pll_d;
		end
	end

	// ****************************************
	// Fill control
	// ****************************************
	wire fill_manual = ctl14_q[`B_FILL_METHOD];
	wire fill_wr = wr14 & fill_manual;
	wire fill_clr = wr14 & wb[`B_FILL] & ~fill_manual & ~overrun_q;
	wire fill_set = is_buf & ~fill_manual & armed_q & ev_i.sync_det;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fill_q <= 1'b0;
			armed_q <= 1'b1;
		end else if (fill_manual) begin
			if (fill_wr) fill_q <= wb[`B_FILL];
			armed_q <= 1'b1;
		end else if (fill_set) begin
			fill_q <= 1'b1;
			armed_q <= 1'b0;
		end else if (fill_clr) begin
			fill_q <= 1'b0;
			armed_q <= 1'b1;
		end
	end

	// ****************************************
	// Selector codes
	// ****************************************
	wire [1:0] c0 = sel13_q[7:6];
	wire [1:0] c1 = sel13_q[5:4];
	wire c0_is0 = (c0 == 2'h0);
	wire c0_is1 = (c0 == 2'h1);
	wire c0_is2 = (c0 == 2'h2);
	wire c1_is0 = (c1 == 2'h0);
	wire c1_is1 = (c1 == 2'h1);
	wire c1_is2 = (c1 == 2'h2);
	wire tx_sel1 = sel13_q[`B_TX_SEL1];
	wire start_sel = ctl14_q[`B_TX_START];
	wire sync_or_adr = ev_i.addr_filt_en ? ev_i.adrs_match : ev_i.sync_det;

	// ****************************************
	// Pin 0 in receive and standby
	// ****************************************
	wire p0_cont = c0_is1 ? ssflag_q : ev_i.sync_det;
	wire p0_buf_hi = c0_is2 ? not_empty : ev_i.sync_det;
	wire p0_buf_lo = c0_is1 ? ev_i.write_byte : 1'b0;
	wire p0_buf = c0[1] ? p0_buf_hi : p0_buf_lo;
	wire p0_pkt_hi = c0_is2 ? not_empty : sync_or_adr;
	wire p0_pkt_lo = c0_is0 ? ev_i.payload_ready : ev_i.write_byte;
	wire p0_pkt = c0[1] ? p0_pkt_hi : p0_pkt_lo;
	wire p0_data = is_pkt ? p0_pkt : p0_buf;
	wire p0_rx = is_cont ? p0_cont : p0_data;

	// ****************************************
	// Pin 0 in transmit
	// ****************************************
	wire p0_tx_thr = is_pkt & ~start_sel;
	wire p0_tx = p0_tx_thr ? ev_i.fifo_threshold : not_empty;

	// ****************************************
	// Pin 1 in receive and standby
	// ****************************************
	wire p1_none = is_pkt & ev_i.crc_ok;
	wire p1_lo = c1_is0 ? p1_none : full;
	wire p1_hi = c1_is2 ? ssflag_q : ev_i.fifo_threshold;
	wire p1_code = (c1_is0 | c1_is1) ? p1_lo : p1_hi;
	wire p1_rx = is_cont ? ev_i.bit_clock : p1_code;

	// ****************************************
	// Pin 1 in transmit
	// ****************************************
	wire p1_tx_data = tx_sel1 ? txdone_q : full;
	wire p1_tx = is_cont ? ev_i.bit_clock : p1_tx_data;

	// ****************************************
	// Pin choice by operating state
	// ****************************************
	wire irq0_d = in_tx ? p0_tx : p0_rx;
	wire irq1_d = in_tx ? p1_tx : p1_rx;

	// ****************************************
	// Transmit start condition
	// ****************************************
	wire start_data = is_pkt ? ev_i.fifo_threshold : full;
	wire start_pick = start_sel ? not_empty : start_data;
	wire start_d = start_pick & in_tx & ~is_cont;
	wire load_d = is_buf ? fill_q : 1'b1;

	// ****************************************
	// Registered interrupt pins
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq0_o <= 1'b0;
			irq1_o <= 1'b0;
		end else begin
			irq0_o <= irq0_d;
			irq1_o <= irq1_d;
		end
	end

	// ****************************************
	// Registered lock pin
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_o <= 1'b0;
			lock_oe_o <= 1'b0;
		end else begin
			lock_o <= pll_q;
			lock_oe_o <= ctl14_q[`B_LOCK_EN];
		end
	end

	// ****************************************
	// Registered FIFO control
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_clear_o <= 1'b0;
			fifo_load_o <= 1'b0;
			tx_start_o <= 1'b0;
		end else begin
			fifo_clear_o <= ovr_clr;
			fifo_load_o <= load_d;
			tx_start_o <= start_d;
		end
	end

endmodule // irq_source_mapping
`default_nettype wire

// ===== tb/irq_source_mapping_props.sv
// Port-level properties of the interrupt mapping block
`timescale 1ns/1ps
`default_nettype none
module irq_source_mapping_props
	import irq_pkg::*;
(
	// Clock, reset and bus
	input wire logic clk_i, input wire logic rst_i,
	input wire logic cyc_i, input wire logic stb_i, input wire logic we_i,
	input wire logic [7:0] adr_i, input wire logic [3:0] sel_i, input wire logic [31:0] dat_i,
	input wire logic ack_o,
	// Events and pins
	input wire op_state_t op_state_i, input wire events_t ev_i,
	input wire logic irq0_o, input wire logic irq1_o, input wire logic lock_oe_o,
	input wire logic fifo_clear_o, input wire logic tx_start_o
);
	// ****
	// Shadow of written registers
	// ****
	logic [7:0] pin_q, ctl_q;
	logic [1:0] mode_q;
	wire logic take = cyc_i && stb_i && !ack_o;
	wire logic wr_ok = take && we_i && sel_i[0];
	wire logic rx_side = op_state_i != OP_TX;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= 8'h00;
			ctl_q <= 8'h01;
			mode_q <= 2'h0;
		end else if (wr_ok) begin
			if (adr_i == 8'h34) pin_q <= dat_i[7:0];
			if (adr_i == 8'h38) ctl_q <= dat_i[7:0];
			if (adr_i == 8'h40) mode_q <= dat_i[1:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_ack_latency: assert property (take |=> ack_o) else $error("ack late");
	a_clear_pulse: assert property (
		fifo_clear_o == $past(wr_ok && adr_i == 8'h34 && dat_i[0])) else $error("clear pulse");
	a_sync_cont: assert property (
		rx_side && mode_q == 2'h0 && pin_q[7:6] != 2'h1 |=> irq0_o == $past(ev_i.sync_det))
		else $error("pin0 sync");
	a_not_empty: assert property (
		rx_side && mode_q == 2'h1 && pin_q[7:6] == 2'h2 |=> irq0_o == !$past(ev_i.fifo_empty))
		else $error("pin0 not empty");
	a_clock_cont: assert property (
		mode_q == 2'h0 |=> irq1_o == $past(ev_i.bit_clock)) else $error("pin1 clock");
	a_full_rx: assert property (
		rx_side && mode_q != 2'h0 && pin_q[5:4] == 2'h1 |=> irq1_o == $past(ev_i.fifo_full))
		else $error("pin1 full rx");
	a_full_tx: assert property (
		!rx_side && mode_q != 2'h0 && !pin_q[3] |=> irq1_o == $past(ev_i.fifo_full))
		else $error("pin1 full tx");
	a_lock_drive: assert property (
		!$past(rst_i) |-> lock_oe_o == $past(ctl_q[0])) else $error("lock enable");
	c_clear: cover property (fifo_clear_o);
	c_lock_off: cover property (lock_oe_o ##1 !lock_oe_o);
	c_start: cover property (tx_start_o);
endmodule // irq_source_mapping_props
bind irq_source_mapping irq_source_mapping_props irq_source_mapping_props_i (.*);
`default_nettype wire

// ===== tb/irq_host_model.sv
// Host side of the lock pin, with a pull-up on the wire
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
	// Lock pin of the device
	input wire logic lock_o,
	input wire logic lock_oe_o,
	// Level the host sees
	output logic pin_o
);
	assign pin_o = lock_oe_o ? lock_o : 1'b1;
endmodule // irq_host_model
`default_nettype wire

// ===== tb/irq_source_mapping_bench.sv
// Register and pin tests of the interrupt mapping block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %h got %h", nm, e, s); end end
module irq_source_mapping_bench;
	import irq_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pin_w;
	logic [7:0] adr_i = 8'h00, rssi_i = 8'h00, q;
	logic [3:0] sel_i = 4'h1;
	logic [31:0] dat_i = 32'h0, dat_o;
	op_state_t op_state_i = OP_STBY;
	events_t ev_i = '0;
	logic ack_o, irq0_o, irq1_o, lock_o, lock_oe_o, fifo_clear_o, fifo_load_o, tx_start_o;
	int bad_count = 0, n_compared = 0;
	initial forever #10 clk_i = ~clk_i;
	irq_source_mapping irq_source_mapping_i (.*);
	irq_host_model irq_host_model_i (.lock_o(lock_o), .lock_oe_o(lock_oe_o), .pin_o(pin_w));
	// ****
	// Bus tasks
	// ****
	task automatic tally_and_finish();
		if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 50) begin bad_count++; tally_and_finish(); end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		`CHK($sformatf("reg %h", a), e, q)
	endtask
	function automatic logic [1:0] exp_pins(input int m, input int c, input int s,
		input events_t v);
		logic p0, p1;
		p0 = 1'b0;
		p1 = 1'b0;
		if (s == 2) begin
			p0 = (m == 2) ? v.fifo_threshold : !v.fifo_empty;
			p1 = (m == 0) ? v.bit_clock : v.fifo_full;
		end else begin
			case (c)
				0: p0 = (m == 0) ? v.sync_det : ((m == 2) & v.payload_ready);
				1: p0 = (m == 0) ? 1'b0 : v.write_byte;
				2: p0 = (m == 0) ? v.sync_det : !v.fifo_empty;
				default: p0 = (m == 2 && v.addr_filt_en) ? v.adrs_match : v.sync_det;
			endcase
			case (c)
				0: p1 = (m == 2) & v.crc_ok;
				1: p1 = v.fifo_full;
				2: p1 = 1'b0;
				default: p1 = v.fifo_threshold;
			endcase
			if (m == 0) p1 = v.bit_clock;
		end
		return {p1, p0};
	endfunction
	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		tally_and_finish();
	end
	initial begin
		int k;
		logic [1:0] e;
		k = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h34, 8'h02);
		rd(8'h38, 8'h01);
		rd(8'h3c, 8'h00);
		rd(8'h44, 8'h00);
		wr(8'h3c, 8'h5a);
		rd(8'h3c, 8'h5a);
		ev_i.fifo_full <= 1'b1;
		rd(8'h34, 8'h06);
		ev_i.fifo_full <= 1'b0;
		ev_i.fifo_empty <= 1'b1;
		ev_i.overrun <= 1'b1;
		@(posedge clk_i);
		ev_i.overrun <= 1'b0;
		rd(8'h34, 8'h01);
		wr(8'h34, 8'h01);
		rd(8'h34, 8'h00);
		wr(8'h3c, 8'h10);
		wr(8'h38, 8'h09);
		rssi_i <= 8'h10;
		rd(8'h38, 8'h09);
		rssi_i <= 8'h11;
		@(posedge clk_i);
		rd(8'h38, 8'h0d);
		rssi_i <= 8'h00;
		wr(8'h38, 8'h0d);
		rd(8'h38, 8'h09);
		wr(8'h38, 8'h01);
		rssi_i <= 8'hff;
		@(posedge clk_i);
		rd(8'h38, 8'h01);
		ev_i.pll_lock <= 1'b1;
		@(posedge clk_i);
		rd(8'h38, 8'h03);
		ev_i.pll_lock <= 1'b0;
		wr(8'h38, 8'h03);
		rd(8'h38, 8'h01);
		wr(8'h38, 8'h00);
		`CHK("lock pin", 1'b1, pin_w)
		wr(8'h40, 8'h01);
		wr(8'h38, 8'h81);
		`CHK("load", 1'b0, fifo_load_o)
		wr(8'h38, 8'hc1);
		`CHK("load", 1'b1, fifo_load_o)
		wr(8'h38, 8'h01);
		ev_i.sync_det <= 1'b1;
		@(posedge clk_i);
		ev_i.sync_det <= 1'b0;
		rd(8'h38, 8'h41);
		wr(8'h38, 8'h41);
		rd(8'h38, 8'h01);
		op_state_i <= OP_TX;
		ev_i.fifo_full <= 1'b1;
		repeat (2) @(posedge clk_i);
		`CHK("start", 1'b1, tx_start_o)
		ev_i.fifo_full <= 1'b0;
		ev_i.fifo_empty <= 1'b0;
		repeat (2) @(posedge clk_i);
		`CHK("start", 1'b0, tx_start_o)
		for (int m = 0; m < 3; m++) begin
			for (int c = 0; c < 4; c++) begin
				wr(8'h40, 8'(m));
				wr(8'h34, {2'(c), 2'(c), c[0], 3'h0});
				for (int s = 0; s < 3; s++) begin
					op_state_i <= op_state_t'(s);
					repeat (6) begin
						@(posedge clk_i);
						ev_i <= events_t'(13'(k * 8'h5b));
						k++;
						repeat (2) @(posedge clk_i);
						e = exp_pins(m, c, s, ev_i);
						`CHK("pin0", e[0], irq0_o)
						if (s != 2 || m == 0 || c[0] == 1'b0) `CHK("pin1", e[1], irq1_o)
					end
				end
			end
		end
		tally_and_finish();
	end
endmodule // irq_source_mapping_bench
`default_nettype wire
